// ==== lane_pack.sv ====
// shifts bits in from and out to one, two or four lanes
// assumes msb-first bytes; pure combinational
`include "spi_lane_cfg.svh"
`timescale 1ns/1ps
module lane_pack (
    input wire logic [1:0] width_i,
    input wire logic [3:0] lanes_i,
    input wire logic [7:0] shift_in_i,
    input wire logic [7:0] shift_out_i,
    output logic [7:0] shift_in_nxt_o,
    output logic [7:0] shift_out_nxt_o,
    output logic [3:0] lanes_o,
    output logic [3:0] nbits_o
);

    // nibbles put bit 7 on lane three, pairs put it on lane one
    always_comb begin
        case (width_i)
            `LANE_W_2: begin
                shift_in_nxt_o = {shift_in_i[5:0], lanes_i[1], lanes_i[0]};
                shift_out_nxt_o = {shift_out_i[5:0], 2'h0};
                lanes_o = {2'h0, shift_out_i[7], shift_out_i[6]};
                nbits_o = 4'h2;
            end
            `LANE_W_4: begin
                shift_in_nxt_o = {shift_in_i[3:0], lanes_i};
                shift_out_nxt_o = {shift_out_i[3:0], 4'h0};
                lanes_o = shift_out_i[7:4];
                nbits_o = 4'h4;
            end
            default: begin
                shift_in_nxt_o = {shift_in_i[6:0], lanes_i[0]};
                shift_out_nxt_o = {shift_out_i[6:0], 1'b0};
                lanes_o = {2'h0, shift_out_i[7], 1'b0};
                nbits_o = 4'h1;
            end
        endcase
    end

endmodule

// ==== multi_lane_spi_slave_interface.sv ====
// serial slave front end with single, extended, dual-lane and quad-lane protocols
// assumes the master drives chip select and serial clock, both sampled here on ref_clk_i;
// the serial clock must stay well below a quarter of ref_clk_i
// rd_data_i must hold the next read byte whenever rd_req_o may pulse
`include "spi_lane_cfg.svh"
`timescale 1ns/1ps

module multi_lane_spi_slave_interface (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [3:0] lane_i,
    output logic [3:0] lane_o,
    output logic [3:0] lane_oe_o,
    input wire logic nv_dual_lane_i,
    input wire logic nv_quad_lane_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_dual_lane_i,
    input wire logic cfg_quad_lane_i,
    input wire logic soft_reset_i,
    output logic dual_lane_protocol_o,
    output logic quad_lane_protocol_o,
    output logic mode3_o,
    output logic ddr_o,
    output logic [7:0] opcode_o,
    output logic opcode_valid_o,
    input wire logic cmd_has_addr_i,
    input wire logic cmd_read_i,
    input wire logic [1:0] cmd_addr_lanes_i,
    input wire logic [1:0] cmd_data_lanes_i,
    input wire logic cmd_ddr_i,
    input wire logic [3:0] cmd_dummy_i,
    output logic [23:0] addr_o,
    output logic addr_valid_o,
    output logic [7:0] wr_data_o,
    output logic wr_valid_o,
    input wire logic [7:0] rd_data_i,
    output logic rd_req_o
);

    // ----------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------
    // r holds every flop of the slave outside pin_sync, n its next value
    spi_lane_pkg::slave_state_t r;
    spi_lane_pkg::slave_state_t n;
    logic [5:0] pins_s;
    logic cs_s;
    logic sck_s;
    logic [3:0] lanes_s;
    logic rise;
    logic fall;

    // select idles high and clock low until real samples arrive
    pin_sync #(
        .WIDTH(6)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i({cs_n_i, sck_i, lane_i}),
        .reset_val_i(6'h20),
        .sync_o(pins_s)
    );

    // lanes are taken from the same stage as sck, so data and edge stay aligned
    assign cs_s = pins_s[5];
    assign sck_s = pins_s[4];
    assign lanes_s = pins_s[3:0];
    // edges compare the synchronised clock with its copy one cycle older
    assign rise = sck_s & ~r.sck_d;
    assign fall = ~sck_s & r.sck_d;

    // ----------------------------------------
    // state and lane packing
    // ----------------------------------------
    logic [1:0] proto_w;
    logic [1:0] wsel;
    logic [7:0] ob_src;
    logic [7:0] sr_nxt;
    logic [7:0] ob_nxt;
    logic [3:0] lanes_nxt;
    logic [3:0] nbits;
    logic [3:0] bsum;
    logic cap;
    logic out_ev;

    // flags are registered, so a width never changes mid-bit
    // opcode width follows the active protocol, quad before dual
    always_comb begin
        if (r.quad_act) begin
            proto_w = `LANE_W_4;
        end else if (r.dual_act) begin
            proto_w = `LANE_W_2;
        end else begin
            proto_w = `LANE_W_1;
        end
    end

    // width of the phase now on the wire
    // dummy and data phases both use the data width
    always_comb begin
        if (r.st == spi_lane_pkg::ST_OPCODE) begin
            wsel = proto_w;
        end else if (r.st == spi_lane_pkg::ST_ADDR) begin
            wsel = r.addr_w;
        end else begin
            wsel = r.data_w;
        end
    end

    // a fresh read byte is loaded once the previous one is fully shifted out
    // rd_data_i is taken at the first output edge of each byte
    assign ob_src = (r.bcnt == 4'h0) ? rd_data_i : r.ob;
    assign bsum = r.bcnt + nbits;

    // one packer serves opcode, address, write and read bytes
    lane_pack u_lane_pack (
        .width_i(wsel),
        .lanes_i(lanes_s),
        .shift_in_i(r.sr),
        .shift_out_i(ob_src),
        .shift_in_nxt_o(sr_nxt),
        .shift_out_nxt_o(ob_nxt),
        .lanes_o(lanes_nxt),
        .nbits_o(nbits)
    );

    // capture on rises; ddr phases also on falls once the first rise is seen
    // the fall ending the opcode comes before armed, so it is never data
    assign cap = rise | (fall & r.ddr & r.armed);

    // output moves on falls, on both edges in ddr, first bit after the last dummy cycle
    // rd_req_o tells the user side that rd_data_i was consumed
    assign out_ev = (r.st == spi_lane_pkg::ST_DATA && r.is_read &&
                     (fall || (r.ddr && rise))) ||
                    (r.st == spi_lane_pkg::ST_DUMMY && r.is_read && fall &&
                     r.dcnt == 4'h0);

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        n = r;
        n.opcode_valid = 1'b0;
        n.addr_valid = 1'b0;
        n.wr_valid = 1'b0;
        n.rd_req = 1'b0;
        n.sck_d = sck_s;
        n.cs_d = cs_s;

        // volatile lane-enable bits: reload after any reset, else software write
        // a write in the same cycle as a soft reset is lost
        if (!r.loaded || soft_reset_i) begin
            n.loaded = 1'b1;
            n.vol_dual = nv_dual_lane_i;
            n.vol_quad = nv_quad_lane_i;
        end else if (cfg_wr_i) begin
            n.vol_dual = cfg_dual_lane_i;
            n.vol_quad = cfg_quad_lane_i;
        end
        // active flags follow the volatile bits, quad masking dual
        n.quad_act = n.vol_quad;
        n.dual_act = n.vol_dual & ~n.vol_quad;

        if (cs_s || soft_reset_i) begin
            // deselected: inputs ignored, every lane released, double rate and arming dropped, per-command widths kept
            n.st = spi_lane_pkg::ST_IDLE;
            n.lane_oe = 4'h0;
            n.lane_out = 4'h0;
            n.ddr = 1'b0;
            n.armed = 1'b0;
        end else begin
            case (r.st)
                spi_lane_pkg::ST_IDLE: begin
                    // only a falling chip select opens a frame; the master never gets a second opcode
                    // sck level at that moment picks mode 0 or mode 3
                    if (r.cs_d) begin
                        n.st = spi_lane_pkg::ST_OPCODE;
                        n.mode3 = sck_s;
                        n.bcnt = 4'h0;
                        n.sr = 8'h00;
                    end
                end
                spi_lane_pkg::ST_OPCODE: begin
                    // opcode is always single data rate
                    // a mode 3 frame opens with a fall, ignored here
                    if (rise) begin
                        n.sr = sr_nxt;
                        n.bcnt = bsum;
                        if (bsum == `BITS_PER_BYTE) begin
                            n.opcode = sr_nxt;
                            n.opcode_valid = 1'b1;
                            n.bcnt = 4'h0;
                            n.st = spi_lane_pkg::ST_DECODE;
                        end
                    end
                end
                spi_lane_pkg::ST_DECODE: begin
                    // the user side answers the opcode within one cycle
                    // lane-wide protocols override the per-opcode lane codes
                    n.addr_w = (proto_w != `LANE_W_1) ? proto_w : cmd_addr_lanes_i;
                    n.data_w = (proto_w != `LANE_W_1) ? proto_w : cmd_data_lanes_i;
                    n.ddr = cmd_ddr_i & r.quad_act;
                    n.armed = 1'b0;
                    n.is_read = cmd_read_i;
                    n.dcnt = cmd_dummy_i;
                    n.acnt = 2'h0;
                    n.bcnt = 4'h0;
                    if (cmd_has_addr_i) begin
                        n.st = spi_lane_pkg::ST_ADDR;
                    end else if (cmd_read_i) begin
                        n.st = spi_lane_pkg::ST_DUMMY;
                    end else begin
                        n.st = spi_lane_pkg::ST_DATA;
                    end
                end
                spi_lane_pkg::ST_ADDR: begin
                    // three address bytes, most significant first
                    // acnt counts finished bytes; the third ends the phase
                    if (cap) begin
                        n.armed = r.armed | rise;
                        n.sr = sr_nxt;
                        n.bcnt = bsum;
                        if (bsum == `BITS_PER_BYTE) begin
                            n.addr = {r.addr[15:0], sr_nxt};
                            n.bcnt = 4'h0;
                            n.acnt = r.acnt + 2'h1;
                            if (r.acnt == `ADDR_LAST_BYTE) begin
                                n.addr_valid = 1'b1;
                                n.st = r.is_read ? spi_lane_pkg::ST_DUMMY :
                                                   spi_lane_pkg::ST_DATA;
                            end
                        end
                    end
                end
                spi_lane_pkg::ST_DUMMY: begin
                    // count whole dummy cycles on falling edges
                    // with no dummy cycles the first fall starts the data
                    if (fall) begin
                        if (r.dcnt == 4'h0) begin
                            n.st = spi_lane_pkg::ST_DATA;
                        end else begin
                            n.dcnt = r.dcnt - 4'h1;
                        end
                    end
                end
                spi_lane_pkg::ST_DATA: begin
                    // write data: gather bytes from the lanes
                    // read data leave through the output block below
                    if (!r.is_read && cap) begin
                        n.armed = r.armed | rise;
                        n.sr = sr_nxt;
                        n.bcnt = bsum;
                        if (bsum == `BITS_PER_BYTE) begin
                            n.wr_data = sr_nxt;
                            n.wr_valid = 1'b1;
                            n.bcnt = 4'h0;
                        end
                    end
                end
                default: begin
                    n.st = spi_lane_pkg::ST_IDLE;
                end
            endcase

            // read data drive; only the lanes of the data width are enabled
            // lanes stay enabled between edges of a read data phase
            if (out_ev) begin
                n.rd_req = (r.bcnt == 4'h0);
                n.ob = ob_nxt;
                n.lane_out = lanes_nxt;
                n.bcnt = (bsum == `BITS_PER_BYTE) ? 4'h0 : bsum;
                case (r.data_w)
                    `LANE_W_2: n.lane_oe = `LANE_OE_DUAL;
                    `LANE_W_4: n.lane_oe = `LANE_OE_QUAD;
                    default: n.lane_oe = `LANE_OE_SINGLE;
                endcase
            end else if (!(r.st == spi_lane_pkg::ST_DATA && r.is_read)) begin
                n.lane_oe = 4'h0;
            end
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // only the phase and the select copy reset to non-zero values
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
            r.st <= spi_lane_pkg::ST_IDLE;
            r.cs_d <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------
    // lane pins are resolved against the master outside this block
    assign lane_o = r.lane_out;
    assign lane_oe_o = r.lane_oe;
    assign dual_lane_protocol_o = r.dual_act;
    assign quad_lane_protocol_o = r.quad_act;
    assign mode3_o = r.mode3;
    assign ddr_o = r.ddr;
    assign opcode_o = r.opcode;
    assign opcode_valid_o = r.opcode_valid;
    assign addr_o = r.addr;
    assign addr_valid_o = r.addr_valid;
    assign wr_data_o = r.wr_data;
    assign wr_valid_o = r.wr_valid;
    assign rd_req_o = r.rd_req;

endmodule

// ==== multi_lane_spi_slave_interface_tb.sv ====
// self-checking bench for the multi-lane serial slave interface
// assumes the master model and the checker are compiled alongside
`timescale 1ns/1ps
module multi_lane_spi_slave_interface_tb;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic junk = 1'b0;
    wire logic cs_n, sck, dual_o, quad_o, mode3, ddr;
    wire logic [3:0] m_o, m_oe, d_o, d_oe, link;
    wire logic [7:0] opc, wdat;
    wire logic [23:0] addr;
    logic nv_dual = 1'b1;
    logic nv_quad = 1'b0;
    logic cfg_wr = 1'b0;
    logic cfg_dual = 1'b0;
    logic cfg_quad = 1'b0;
    logic soft_rst = 1'b0;
    logic rd = 1'b0;
    logic dd = 1'b0;
    logic [1:0] aw = 2'h0;
    logic [1:0] dw = 2'h0;
    logic [7:0] rd_data = 8'h00;
    logic [3:0] oe_acc = 4'h0;
    logic ddr_acc = 1'b0;
    logic cs_q = 1'b1;
    logic [3:0] av_n = 4'h0;
    logic [3:0] wv_n = 4'h0;
    wire logic av, wv;
    logic [31:0] seed = 32'he2e9c724;
    logic [1:0] ext_a [4] = '{2'h0, 2'h0, 2'h1, 2'h2};
    logic [1:0] ext_d [4] = '{2'h1, 2'h2, 2'h1, 2'h2};
    int errors = 0;
    int compares = 0;

    // ----------------------------------------
    // clock, released lanes toggle, lane resolution
    // ----------------------------------------
    initial begin
        forever #50 clk = ~clk;
    end
    // per-frame tallies restart at each select
    always @(posedge clk) begin
        junk <= ~junk;
        cs_q <= cs_n;
        oe_acc <= (cs_q & ~cs_n) ? 4'h0 : oe_acc | d_oe;
        ddr_acc <= (cs_q & ~cs_n) ? 1'b0 : ddr_acc | ddr;
        av_n <= (cs_q & ~cs_n) ? 4'h0 : av_n + {3'h0, av};
        wv_n <= (cs_q & ~cs_n) ? 4'h0 : wv_n + {3'h0, wv};
    end
    assign link = (d_oe & d_o) | (~d_oe & m_oe & m_o) | (~d_oe & ~m_oe & {4{junk}});

    multi_lane_spi_slave_interface DUT (
        .ref_clk_i(clk), .arst_n_i(arst_n), .cs_n_i(cs_n), .sck_i(sck), .lane_i(link),
        .lane_o(d_o), .lane_oe_o(d_oe), .nv_dual_lane_i(nv_dual), .nv_quad_lane_i(nv_quad),
        .cfg_wr_i(cfg_wr), .cfg_dual_lane_i(cfg_dual), .cfg_quad_lane_i(cfg_quad),
        .soft_reset_i(soft_rst), .dual_lane_protocol_o(dual_o), .quad_lane_protocol_o(quad_o),
        .mode3_o(mode3), .ddr_o(ddr), .opcode_o(opc), .opcode_valid_o(),
        .cmd_has_addr_i(1'b1), .cmd_read_i(rd), .cmd_addr_lanes_i(aw),
        .cmd_data_lanes_i(dw), .cmd_ddr_i(dd), .cmd_dummy_i(4'h0), .addr_o(addr),
        .addr_valid_o(av), .wr_data_o(wdat), .wr_valid_o(wv), .rd_data_i(rd_data), .rd_req_o()
    );
    spi_master_model m (.ref_clk_i(clk), .lane_i(link), .cs_n_o(cs_n), .sck_o(sck),
        .lane_o(m_o), .lane_oe_o(m_oe));

    // random source and expected lane enables of a read
    function automatic logic [31:0] nxt();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction
    function automatic logic [3:0] lanes_of(input logic [1:0] wc);
        return wc == 2'h0 ? 4'h2 : (wc == 2'h1 ? 4'h3 : 4'hf);
    endfunction

    task automatic check(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // volatile lane bits written, outputs follow one edge later
    task automatic cfg(input logic d, input logic q);
        cfg_dual = d;
        cfg_quad = q;
        cfg_wr = 1'b1;
        @(posedge clk);
        #1;
        cfg_wr = 1'b0;
        @(posedge clk);
        #1;
        check(quad_o, q);
        check(dual_o, d & ~q);
    endtask

    // one framed operation: opcode, address, then write or read data
    task automatic frame(input logic m3, input logic r, input logic [1:0] ow,
                         input logic [1:0] a, input logic [1:0] d, input logic x);
        logic [31:0] s;
        logic [7:0] q;
        logic [7:0] op;
        logic [23:0] ad;
        logic [7:0] wd;
        logic dq;
        s = nxt();
        op = s[7:0];
        ad = s[31:8];
        s = nxt();
        wd = s[7:0];
        rd_data = s[15:8];
        dq = x & (ow == 2'h2);
        rd = r;
        aw = a;
        dw = d;
        dd = x;
        m.sel(m3);
        m.xfer(ow, 1'b0, op, q);
        if (dq) begin
            m.lead();
            for (int i = 0; i < 4; i++) m.dxfer(i < 3 ? ad[23 - 8 * i -: 8] : wd);
        end else begin
            for (int i = 0; i < 3; i++) m.xfer(a, 1'b0, ad[23 - 8 * i -: 8], q);
            for (int i = 0; i < 2; i++) begin
                m.xfer(d, r, wd, q);
                if (r) check(q, rd_data);
            end
        end
        m.desel(m3);
        check(opc, op);
        check(addr, ad);
        check(mode3, m3);
        check(ddr_acc, dq);
        check(oe_acc, r ? lanes_of(d) : 4'h0);
        if (!r) check(wdat, wd);
        check(av_n, 4'h1);
        check(wv_n, r ? 4'h0 : (dq ? 4'h1 : 4'h2));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [31:0] s;
        repeat (8) @(posedge clk);
        #1;
        arst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(dual_o, 1'b1);
        check(d_oe, 4'h0);
        for (int p = 0; p < 3; p++) begin
            cfg(p == 1, p == 2);
            for (int k = 0; k < 4; k++) frame(k[0], k[1], p[1:0], p[1:0], p[1:0], 1'b0);
        end
        cfg(1'b1, 1'b1);
        cfg(1'b0, 1'b0);
        for (int k = 0; k < 8; k++) begin
            s = nxt();
            frame(s[0], k[0], 2'h0, ext_a[k >> 1], ext_d[k >> 1], s[1]);
        end
        cfg(1'b0, 1'b1);
        frame(1'b0, 1'b0, 2'h2, 2'h2, 2'h2, 1'b1);
        nv_quad = 1'b1;
        soft_rst = 1'b1;
        @(posedge clk);
        #1;
        soft_rst = 1'b0;
        @(posedge clk);
        #1;
        check(quad_o, 1'b1);
        check(dual_o, 1'b0);
        complete_run();
    end

    // hang guard
    initial begin
        repeat (100000) @(posedge clk);
        errors++;
        complete_run();
    end
endmodule

// ==== pin_sync.sv ====
// two-flop synchroniser for pins arriving from outside the clock domain
// assumes the inputs are asynchronous levels
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    input wire logic [WIDTH-1:0] reset_val_i,
    output logic [WIDTH-1:0] sync_o
);

    typedef struct packed {
        logic [1:0] fill;
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } sync_state_t;

    sync_state_t r;
    sync_state_t n;

    // first stage feeds only the second stage
    always_comb begin
        n = r;
        n.s1 = async_i;
        n.s2 = r.s1;
        n.fill = {r.fill[0], 1'b1};
    end

    // registers start from zero; reset_val_i is applied at the output while unloaded
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // reset_val_i stands until the second stage holds a real sample
    assign sync_o = r.fill[1] ? r.s2 : reset_val_i;

endmodule

// ==== spi_lane_cfg.svh ====
// constants for the multi-lane serial slave interface
// assumes inclusion by bare name from every file that needs it
`ifndef SPI_LANE_CFG_SVH
`define SPI_LANE_CFG_SVH

// ----------------------------------------
// lane width codes for one edge of the serial clock
// ----------------------------------------
`define LANE_W_1 2'h0
`define LANE_W_2 2'h1
`define LANE_W_4 2'h2

// ----------------------------------------
// second configuration register field positions
// ----------------------------------------
`define CFG2_DUAL_BIT 4
`define CFG2_QUAD_BIT 6

// ----------------------------------------
// framing counts and lane enable patterns
// ----------------------------------------
`define BITS_PER_BYTE 4'h8
`define ADDR_LAST_BYTE 2'h2
`define LANE_OE_SINGLE 4'h2
`define LANE_OE_DUAL 4'h3
`define LANE_OE_QUAD 4'hf

`endif

// ==== spi_lane_monitor.sv ====
// port checker for the multi-lane serial slave interface
// assumes binding into multi_lane_spi_slave_interface by name
`timescale 1ns/1ps
module spi_lane_monitor (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [3:0] lane_oe_o,
    input wire logic nv_quad_lane_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_dual_lane_i,
    input wire logic cfg_quad_lane_i,
    input wire logic soft_reset_i,
    input wire logic dual_lane_protocol_o,
    input wire logic quad_lane_protocol_o,
    input wire logic mode3_o,
    input wire logic ddr_o,
    input wire logic opcode_valid_o,
    input wire logic wr_valid_o,
    input wire logic rd_req_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);

    // ----------------------------------------
    // clock level at select and opcode seen in this frame
    // ----------------------------------------
    logic sel_sck_r;
    logic op_seen_r;
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sel_sck_r <= 1'b0;
            op_seen_r <= 1'b0;
        end else begin
            sel_sck_r <= $fell(cs_n_i) ? sck_i : sel_sck_r;
            op_seen_r <= !cs_n_i && (op_seen_r || opcode_valid_o);
        end
    end

    deselect_release_a: assert property (cs_n_i [*8] |-> lane_oe_o == 4'h0)
        else $error("lanes driven while deselected");
    oe_shape_a: assert property (lane_oe_o inside {4'h0, 4'h2, 4'h3, 4'hf})
        else $error("unexpected lane enable pattern");
    quad_wins_a: assert property (quad_lane_protocol_o |-> !dual_lane_protocol_o)
        else $error("dual and quad protocols both active");
    cfg_quad_a: assert property (cfg_wr_i && !soft_reset_i |=>
        quad_lane_protocol_o == $past(cfg_quad_lane_i)) else $error("quad bit write lost");
    cfg_dual_a: assert property (cfg_wr_i && !soft_reset_i |=>
        dual_lane_protocol_o == $past(cfg_dual_lane_i && !cfg_quad_lane_i))
        else $error("dual bit write lost");
    soft_reload_a: assert property (soft_reset_i |=>
        quad_lane_protocol_o == $past(nv_quad_lane_i)) else $error("no reload on reset");
    one_opcode_a: assert property (op_seen_r |-> !opcode_valid_o)
        else $error("second opcode in one frame");
    mode_pick_a: assert property (opcode_valid_o |-> mode3_o == sel_sck_r)
        else $error("clock mode not taken at select");
    ddr_quad_a: assert property (ddr_o |-> quad_lane_protocol_o)
        else $error("double rate outside quad protocol");
    req_selected_a: assert property (rd_req_o |-> !cs_n_i)
        else $error("read request while deselected");

    cover property (opcode_valid_o && mode3_o);
    cover property (ddr_o && wr_valid_o);
    cover property (rd_req_o && lane_oe_o == 4'hf);
endmodule

bind multi_lane_spi_slave_interface spi_lane_monitor mon (.*);

// ==== spi_lane_pkg.sv ====
// types for the multi-lane serial slave interface
// assumes nothing beyond a SystemVerilog compiler
package spi_lane_pkg;

    // ----------------------------------------
    // transaction phases, one-hot
    // ----------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_OPCODE = 6'h02,
        ST_DECODE = 6'h04,
        ST_ADDR   = 6'h08,
        ST_DUMMY  = 6'h10,
        ST_DATA   = 6'h20
    } phase_t;

    // ----------------------------------------
    // complete state of the slave apart from pin_sync
    // ----------------------------------------
    typedef struct packed {
        phase_t st;
        logic cs_d;
        logic sck_d;
        logic mode3;
        logic loaded;
        logic vol_dual;
        logic vol_quad;
        logic dual_act;
        logic quad_act;
        logic [1:0] addr_w;
        logic [1:0] data_w;
        logic ddr;
        logic armed;
        logic is_read;
        logic [3:0] dcnt;
        logic [3:0] bcnt;
        logic [1:0] acnt;
        logic [7:0] sr;
        logic [7:0] ob;
        logic [7:0] opcode;
        logic opcode_valid;
        logic [23:0] addr;
        logic addr_valid;
        logic [7:0] wr_data;
        logic wr_valid;
        logic rd_req;
        logic [3:0] lane_out;
        logic [3:0] lane_oe;
    } slave_state_t;

endpackage

// ==== spi_master_model.sv ====
// serial bus master driving select, clock and lanes
// assumes the bench resolves the lanes and calls the tasks
`timescale 1ns/1ps
module spi_master_model (
    input wire logic ref_clk_i,
    input wire logic [3:0] lane_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] lane_o,
    output logic [3:0] lane_oe_o
);
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        lane_o = 4'h0;
        lane_oe_o = 4'h0;
    end

    // ----------------------------------------
    // link tasks; half clock period is 4 reference cycles
    // ----------------------------------------
    task automatic w(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask

    // idle clock level picks the mode, then select
    task automatic sel(input logic m3);
        sck_o = m3;
        w(8);
        cs_n_o = 1'b0;
        w(8);
    endtask

    // one sdr byte msb first; reads sample just before the next fall
    task automatic xfer(input logic [1:0] wc, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
        logic [7:0] sh;
        sh = d;
        q = 8'h00;
        repeat (8 >> wc) begin
            sck_o = 1'b0;
            lane_oe_o = rd ? 4'h0 : 4'hf >> (3'h4 - (3'h1 << wc));
            lane_o = wc == 2'h0 ? {3'h0, sh[7]} : (wc == 2'h1 ? {2'h0, sh[7:6]} : sh[7:4]);
            sh = sh << (4'h1 << wc);
            w(4);
            sck_o = 1'b1;
            w(4);
            q = wc == 2'h0 ? {q[6:0], lane_i[1]} : (wc == 2'h1 ? {q[5:0], lane_i[1:0]} :
                {q[3:0], lane_i});
        end
    endtask

    // uncaptured fall that opens a double rate phase
    task automatic lead();
        sck_o = 1'b0;
        w(4);
    endtask

    // one double rate byte, a nibble per clock edge
    task automatic dxfer(input logic [7:0] d);
        lane_oe_o = 4'hf;
        for (int i = 0; i < 2; i++) begin
            lane_o = i == 0 ? d[7:4] : d[3:0];
            w(2);
            sck_o = ~sck_o;
            w(2);
        end
    endtask

    // end of operation: release everything
    task automatic desel(input logic m3);
        sck_o = m3;
        w(8);
        cs_n_o = 1'b1;
        lane_oe_o = 4'h0;
        w(8);
    endtask
endmodule
